// >>> rtl/lfs_responder.sv
`timescale 1ns/1ps
// Summary of operation
// - Master requests full status; device answers in the following response slot.
// - Request: id 0x3c, 0x80, command 0x01 with bit7, 11+address, rest 0xff.
// - Serving clears warning, shutdown, led codes, supply-reset and retry flags.
// - A flag whose fault still persists is set again after the clear.
// - Temperature info field reports the live, unlatched temperature state.
// - Warning and shutdown are latched until serving the full-status response clears them.
// - Led code 000 means no fault; 011 open resistor or anode short.
// - Led code 101 means cathode-to-anode path open.
// - Led code 010 means cathode shorted to ground.
// - Derate level 15 is full current, each step down removes 6.25 percent.
// - Both frames end in a classic checksum over the data bytes only.
// - Bit error flag sets when sent and monitored bus levels differ.
// - Node address compared against the request is six bits wide.
module lfs_responder
	import lfs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [5:0] node_addr,
	input wire logic hdr_valid,
	input wire logic [5:0] hdr_id,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic frame_abort,
	input wire logic hdr_err_evt,
	input wire logic data_err_evt,
	input wire logic tx_bit,
	input wire logic bit_sample,
	input wire logic mon_bit,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic resp_armed,
	input wire logic temp_warn_pin,
	input wire logic temp_sd_pin,
	input wire logic uv_pin,
	input wire logic [1:0] temp_info_pin,
	input wire logic [2:0] led_open_res_pin,
	input wire logic [2:0] led_open_cath_pin,
	input wire logic [2:0] led_short_gnd_pin,
	input wire logic retry_active,
	input wire logic thermal_derate_on,
	input wire logic [3:0] thermal_derate_level,
	input wire logic [2:0] led_enable,
	input wire logic leds_on,
	input wire logic [3:0] group_select
);
	lfs_core_s r_reg;
	lfs_core_s r_next;
	lfs_pins_s pins;
	logic [7:0][7:0] snap;
	logic [7:0] snap_sum;
	logic [7:0] exp_byte;
	logic [3:0] derate;
	logic take;
	logic data_bad;
	logic [7:0] chk_sum;

	lfs_flag_if flags();

	assign pins = {mon_bit, temp_warn_pin, temp_sd_pin, uv_pin,
		temp_info_pin, led_open_res_pin, led_open_cath_pin,
		led_short_gnd_pin};

	lfs_fault_latch u_latch (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.pins(pins),
		.retry_active(retry_active),
		.flags(flags)
	);

	// ----------------------------------------
	// response snapshot
	// ----------------------------------------
	// outside derating the output runs at full current
	assign derate = thermal_derate_on ? thermal_derate_level :
		LFS_DERATE_FULL;
	assign snap[0] = {LFS_ADDR_TOP, node_addr};
	assign snap[1] = LFS_FILL;
	assign snap[2] = {5'h1f, flags.lin_err};
	assign snap[3] = {2'h3, flags.uv, flags.vbb_rst, flags.thermal_shutdown_flag,
		flags.tw, flags.tinfo};
	assign snap[4] = {derate, flags.retry, flags.led_code[0]};
	assign snap[5] = {1'b1, flags.led_code[2], 1'b1,
		flags.led_code[1]};
	assign snap[6] = {led_enable[2], led_enable[1], led_enable[0],
		leds_on, group_select};
	assign snap[7] = LFS_FILL;

	always_comb begin
		snap_sum = 8'h00;
		for (int i = 0; i < LFS_NB; i++) begin
			snap_sum = lfs_add(snap_sum, snap[i]);
		end
	end

	// ----------------------------------------
	// request byte check
	// ----------------------------------------
	always_comb begin
		case (r_reg.cnt)
			4'h0: exp_byte = LFS_APP_CMD;
			4'h1: exp_byte = {1'b1, LFS_CMD_FULL};
			4'h2: exp_byte = {LFS_ADDR_TOP, node_addr};
			default: exp_byte = LFS_FILL;
		endcase
	end

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		take = 1'b0;
		data_bad = 1'b0;
		if (hdr_valid) begin
			// a new header always ends whatever frame was open
			r_next.armed = 1'b0;
			r_next.state = LFS_IDLE;
			if (hdr_id == LFS_ID_REQ) begin
				r_next.state = LFS_RX;
				r_next.cnt = 4'h0;
				r_next.sum = 8'h00;
				r_next.ok = 1'b1;
			end else if (hdr_id == LFS_ID_RSP && r_reg.armed) begin
				take = 1'b1;
				r_next.state = LFS_TX;
				r_next.cnt = 4'h0;
				r_next.resp = snap;
				r_next.csum = ~snap_sum;
				r_next.out = snap[0];
			end
		end else if (frame_abort) begin
			r_next.state = LFS_IDLE;
			r_next.armed = 1'b0;
		end else begin
			case (r_reg.state)
				LFS_RX: begin
					if (rx_valid && r_reg.cnt == LFS_CSUM_IDX) begin
						r_next.state = LFS_IDLE;
						if (rx_data != ~r_reg.sum) begin
							data_bad = 1'b1;
						end else begin
							r_next.armed = r_reg.ok;
						end
					end else if (rx_valid) begin
						r_next.sum = lfs_add(r_reg.sum, rx_data);
						r_next.ok = r_reg.ok && (rx_data == exp_byte);
						r_next.cnt = r_reg.cnt + 4'h1;
					end
				end
				LFS_TX: begin
					if (tx_ready && r_reg.cnt == LFS_CSUM_IDX) begin
						r_next.state = LFS_IDLE;
					end else if (tx_ready) begin
						r_next.cnt = r_reg.cnt + 4'h1;
						if (r_reg.cnt == LFS_LAST_IDX) begin
							r_next.out = r_reg.csum;
						end else begin
							r_next.out = r_reg.resp[r_reg.cnt[2:0] + 3'h1];
						end
					end
				end
				default: begin
					r_next.state = r_reg.state;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			r_reg <= LFS_CORE_RST;
		end else if (clk_en) begin
			r_reg <= r_next;
		end
	end

	// snapshot and clear land on the same edge, so nothing is lost
	assign flags.clr = take;
	assign flags.data_evt = data_err_evt | data_bad;
	assign flags.hdr_evt = hdr_err_evt;
	assign flags.tx_bit = tx_bit;
	assign flags.bit_sample = bit_sample;

	assign tx_valid = (r_reg.state == LFS_TX);
	assign tx_data = r_reg.out;
	assign resp_armed = r_reg.armed;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			chk_sum <= 8'h00;
		end else if (clk_en) begin
			if (take) begin
				chk_sum <= 8'h00;
			end else if (tx_valid && tx_ready &&
				r_reg.cnt != LFS_CSUM_IDX) begin
				chk_sum <= lfs_add(chk_sum, tx_data);
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b || !clk_en);

	sequence s_take;
		hdr_valid && hdr_id == LFS_ID_RSP && r_reg.armed;
	endsequence
	sequence s_last_out;
		tx_valid && tx_ready && r_reg.cnt == LFS_CSUM_IDX &&
			!hdr_valid && !frame_abort;
	endsequence

	a_take_clears: assert property (s_take |-> flags.clr ##1
		(tx_valid && r_reg.cnt == 4'h0))
		else $error("serve did not clear and start");
	a_first_byte: assert property (s_take |=>
		tx_data == {LFS_ADDR_TOP, $past(node_addr)})
		else $error("first response byte wrong");
	a_no_arm_silent: assert property (hdr_valid &&
		hdr_id == LFS_ID_RSP && !r_reg.armed |=> !tx_valid)
		else $error("response without request");
	a_frame_end: assert property (s_last_out |=>
		r_reg.state == LFS_IDLE && !tx_valid)
		else $error("response did not end after checksum");
	a_tx_csum: assert property (tx_valid &&
		r_reg.cnt == LFS_CSUM_IDX |-> tx_data == ~chk_sum)
		else $error("response checksum wrong");
	// pin to snapshot: two sync stages plus the take edge
	a_tinfo_live: assert property (s_take |=>
		r_reg.resp[3][1:0] == $past(temp_info_pin, 3))
		else $error("temperature info not live");
	a_derate_map: assert property (s_take |=>
		r_reg.resp[4][7:4] == ($past(thermal_derate_on) ?
		$past(thermal_derate_level) : LFS_DERATE_FULL))
		else $error("derate field wrong");
	a_addr_check: assert property (r_reg.state == LFS_RX &&
		rx_valid && !hdr_valid && !frame_abort && r_reg.cnt == 4'h2 &&
		rx_data != {LFS_ADDR_TOP, node_addr} |=> !r_reg.ok)
		else $error("foreign address accepted");
	a_fill_byte: assert property (tx_valid && r_reg.cnt == 4'h1
		|-> tx_data == LFS_FILL) else $error("fill byte wrong");
endmodule

// >>> rtl/lfs_pkg.sv
package lfs_pkg;
	// ----------------------------------------
	// frame constants
	// ----------------------------------------
	localparam logic [5:0] LFS_ID_REQ = 6'h3c;
	localparam logic [5:0] LFS_ID_RSP = 6'h3d;
	localparam logic [7:0] LFS_APP_CMD = 8'h80;
	localparam logic [6:0] LFS_CMD_FULL = 7'h01;
	localparam logic [7:0] LFS_FILL = 8'hff;
	localparam logic [1:0] LFS_ADDR_TOP = 2'h3;
	localparam int LFS_NB = 8;
	localparam int LFS_LEDS = 3;
	localparam logic [3:0] LFS_LAST_IDX = 4'h7;
	localparam logic [3:0] LFS_CSUM_IDX = 4'h8;
	localparam logic [3:0] LFS_DERATE_FULL = 4'hf;
	// ----------------------------------------
	// led fault codes
	// ----------------------------------------
	localparam logic [2:0] LFS_LED_OK = 3'h0;
	localparam logic [2:0] LFS_LED_OPEN_RES = 3'h3;
	localparam logic [2:0] LFS_LED_OPEN_CA = 3'h5;
	localparam logic [2:0] LFS_LED_SHORT = 3'h2;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		LFS_IDLE = 3'b001,
		LFS_RX = 3'b010,
		LFS_TX = 3'b100
	} lfs_state_e;
	typedef struct packed {
		logic mon;
		logic warn;
		logic sd;
		logic uv;
		logic [1:0] tinfo;
		logic [2:0] open_res;
		logic [2:0] open_cath;
		logic [2:0] short_gnd;
	} lfs_pins_s;
	typedef struct packed {
		lfs_state_e state;
		logic [3:0] cnt;
		logic [7:0] sum;
		logic ok;
		logic armed;
		logic [7:0][7:0] resp;
		logic [7:0] csum;
		logic [7:0] out;
	} lfs_core_s;
	typedef struct packed {
		lfs_pins_s s1;
		lfs_pins_s s2;
		logic [1:0] tx_d;
		logic [1:0] smp_d;
		logic tw;
		logic thermal_shutdown_flag;
		logic vbb;
		logic retry;
		logic [2:0] lin_err;
		logic [2:0][2:0] code;
	} lfs_latch_s;
	localparam lfs_core_s LFS_CORE_RST = '{state: LFS_IDLE, default: '0};
	// supply-reset flag comes up set: a reset just happened
	localparam lfs_latch_s LFS_LATCH_RST = '{vbb: 1'b1, default: '0};
	// classic checksum step: 8-bit add with end-around carry
	function automatic logic [7:0] lfs_add(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction
endpackage

// >>> rtl/lfs_flag_if.sv
`timescale 1ns/1ps
interface lfs_flag_if;
	logic clr;
	logic data_evt;
	logic hdr_evt;
	logic tx_bit;
	logic bit_sample;
	logic tw;
	logic thermal_shutdown_flag;
	logic vbb_rst;
	logic retry;
	logic uv;
	logic [1:0] tinfo;
	logic [2:0][2:0] led_code;
	logic [2:0] lin_err;
	modport core(output clr, data_evt, hdr_evt, tx_bit, bit_sample,
		input tw, thermal_shutdown_flag, vbb_rst, retry, uv, tinfo, led_code, lin_err);
	modport latch(input clr, data_evt, hdr_evt, tx_bit, bit_sample,
		output tw, thermal_shutdown_flag, vbb_rst, retry, uv, tinfo, led_code, lin_err);
endinterface

// >>> rtl/lfs_fault_latch.sv
`timescale 1ns/1ps
module lfs_fault_latch
	import lfs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire lfs_pins_s pins,
	input wire logic retry_active,
	lfs_flag_if.latch flags
);
	lfs_latch_s r_reg;
	lfs_latch_s r_next;
	logic [2:0][2:0] raw_code;
	logic bit_evt;

	// ----------------------------------------
	// detector to fault code
	// ----------------------------------------
	genvar i;
	for (i = 0; i < LFS_LEDS; i++) begin : g_led
		// a ground short masks the open cases on the same cathode
		assign raw_code[i] = r_reg.s2.short_gnd[i] ? LFS_LED_SHORT :
			r_reg.s2.open_cath[i] ? LFS_LED_OPEN_CA :
			r_reg.s2.open_res[i] ? LFS_LED_OPEN_RES : LFS_LED_OK;
	end

	// tx bit and strobe delayed to line up with the synced bus level
	assign bit_evt = r_reg.smp_d[1] && (r_reg.tx_d[1] != r_reg.s2.mon);

	always_comb begin
		r_next = r_reg;
		r_next.s1 = pins;
		r_next.s2 = r_reg.s1;
		r_next.tx_d = {r_reg.tx_d[0], flags.tx_bit};
		r_next.smp_d = {r_reg.smp_d[0], flags.bit_sample};
		// live condition wins over the clear
		r_next.tw = r_reg.s2.warn | (r_reg.tw & ~flags.clr);
		r_next.thermal_shutdown_flag = r_reg.s2.sd | (r_reg.thermal_shutdown_flag & ~flags.clr);
		r_next.retry = retry_active | (r_reg.retry & ~flags.clr);
		r_next.vbb = r_reg.vbb & ~flags.clr;
		r_next.lin_err = {flags.data_evt, flags.hdr_evt, bit_evt} |
			(r_reg.lin_err & {3{~flags.clr}});
		for (int k = 0; k < LFS_LEDS; k++) begin
			// first fault code seen is held until cleared
			if (r_reg.code[k] != LFS_LED_OK && !flags.clr) begin
				r_next.code[k] = r_reg.code[k];
			end else begin
				r_next.code[k] = raw_code[k];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			r_reg <= LFS_LATCH_RST;
		end else if (clk_en) begin
			r_reg <= r_next;
		end
	end

	assign flags.tw = r_reg.tw;
	assign flags.thermal_shutdown_flag = r_reg.thermal_shutdown_flag;
	assign flags.vbb_rst = r_reg.vbb;
	assign flags.retry = r_reg.retry;
	assign flags.uv = r_reg.s2.uv;
	assign flags.tinfo = r_reg.s2.tinfo;
	assign flags.led_code = r_reg.code;
	assign flags.lin_err = r_reg.lin_err;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b || !clk_en);

	a_flag_reassert: assert property (flags.clr && r_reg.s2.warn
		|=> flags.tw) else $error("warning flag lost while present");
	a_flag_latched: assert property (flags.thermal_shutdown_flag && !flags.clr
		|=> flags.thermal_shutdown_flag) else $error("shutdown flag dropped uncleared");
	a_bit_error: assert property (bit_evt |=> flags.lin_err[0])
		else $error("bit error not flagged");
	a_led_short: assert property ((flags.clr ||
		r_reg.code[0] == LFS_LED_OK) && r_reg.s2.short_gnd[0]
		|=> flags.led_code[0] == LFS_LED_SHORT)
		else $error("short code wrong");
	a_led_open_ca: assert property ((flags.clr ||
		r_reg.code[1] == LFS_LED_OK) && r_reg.s2.open_cath[1] &&
		!r_reg.s2.short_gnd[1]
		|=> flags.led_code[1] == LFS_LED_OPEN_CA)
		else $error("open cathode code wrong");
endmodule

// >>> verification/lfs_master_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// lin master side: headers, request bytes, pickup
// ------------------------------------------------
module lfs_master_model
	import lfs_pkg::*;
(
	input wire logic core_clk,
	output logic hdr_valid,
	output logic [5:0] hdr_id,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic tx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data
);
	initial begin
		hdr_valid = 1'b0;
		hdr_id = 6'h00;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// classic checksum: data bytes only, end-around carry, inverted
	function automatic logic [7:0] csum(input logic [7:0] b[8]);
		logic [8:0] s;
		s = 9'h000;
		for (int i = 0; i < 8; i++) begin
			s = {1'b0, s[7:0]} + {1'b0, b[i]} + {8'h00, s[8]};
		end
		return ~(s[7:0] + {7'h00, s[8]});
	endfunction
	// ------------------------------------------------
	// tasks start just after an edge and end likewise
	// ------------------------------------------------
	// released lines show the inverse, never the last value
	task automatic hdr(input logic [5:0] id);
		hdr_valid = 1'b1;
		hdr_id = id;
		@(posedge core_clk);
		#1;
		hdr_valid = 1'b0;
		hdr_id = ~id;
	endtask
	// bad flips bit 0 of the checksum to break the frame on purpose
	task automatic req(input logic [7:0] b[8], input logic bad);
		logic [7:0] c;
		c = csum(b) ^ {7'h00, bad};
		hdr(LFS_ID_REQ);
		for (int i = 0; i < 9; i++) begin
			rx_valid = 1'b1;
			rx_data = (i == 8) ? c : b[i];
			@(posedge core_clk);
			#1;
		end
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask
	// slow > 0 stalls that many cycles between accepted bytes
	task automatic rsp(input int slow, output logic [7:0] got[9],
		output int n);
		logic v;
		logic [7:0] d;
		n = 0;
		hdr(LFS_ID_RSP);
		for (int k = 0; k < 60 && n < 9; k++) begin
			tx_ready = (k % (slow + 1)) == slow;
			// taken before the edge: settled since the last one
			v = tx_valid;
			d = tx_data;
			@(posedge core_clk);
			if (v === 1'b1 && tx_ready) begin
				got[n] = d;
				n++;
			end
			#1;
		end
		tx_ready = 1'b0;
	endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import lfs_pkg::*;
;
	logic core_clk, rst_b, hdr_valid, rx_valid, tx_ready, tx_valid;
	logic hdr_err_evt, data_err_evt, tx_bit, bit_sample, mon_bit;
	logic resp_armed, temp_warn_pin, temp_sd_pin, uv_pin, retry_active;
	logic thermal_derate_on, leds_on, clk_en, frame_abort;
	logic [5:0] hdr_id;
	logic [7:0] rx_data, tx_data;
	logic [1:0] temp_info_pin;
	logic [2:0] led_open_res_pin, led_open_cath_pin, led_short_gnd_pin;
	logic [2:0] led_enable;
	logic [3:0] thermal_derate_level, group_select;
	logic [5:0] addr = 6'h15;
	int failures = 0;
	int checks = 0;
	lfs_responder dut (.core_clk, .rst_b, .clk_en, .node_addr(addr),
		.hdr_valid, .hdr_id, .rx_valid, .rx_data, .frame_abort,
		.hdr_err_evt, .data_err_evt, .tx_bit, .bit_sample, .mon_bit,
		.tx_ready, .tx_valid, .tx_data, .resp_armed, .temp_warn_pin,
		.temp_sd_pin, .uv_pin, .temp_info_pin, .led_open_res_pin,
		.led_open_cath_pin, .led_short_gnd_pin, .retry_active,
		.thermal_derate_on, .thermal_derate_level, .led_enable, .leds_on,
		.group_select);
	lfs_master_model m (.core_clk, .hdr_valid, .hdr_id, .rx_valid,
		.rx_data, .tx_ready, .tx_valid, .tx_data);
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// valid request, then the whole response compared byte by byte
	task automatic status(input logic [7:0] e3, e4, e5, e6, input int slow);
		logic [7:0] b[8];
		logic [7:0] d[8];
		logic [7:0] g[9];
		int n;
		b = '{8'h80, 8'h81, {2'b11, addr}, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
		m.req(b, 1'b0);
		tick(1);
		chk("armed", resp_armed, 8'h01);
		d = '{{2'b11, addr}, 8'hff, e3, e4, e5, e6,
			{led_enable, leds_on, group_select}, 8'hff};
		m.rsp(slow, g, n);
		chk("rsp count", n[7:0], 8'h09);
		for (int i = 0; i < 9; i++) begin
			chk("rsp byte", g[i], (i == 8) ? m.csum(d) : d[i]);
		end
	endtask
	task automatic refuse(input logic [7:0] c, a, input logic bad);
		logic [7:0] b[8];
		logic [7:0] g[9];
		int n;
		b = '{8'h80, c, a, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
		m.req(b, bad);
		tick(1);
		chk("armed", resp_armed, 8'h00);
		m.rsp(0, g, n);
		chk("rsp count", n[7:0], 8'h00);
	endtask
	// fault pulses on the detectors, gone again before the read
	task automatic led(input logic [2:0] r, o, s, input logic [7:0] e5, e6);
		led_open_res_pin = r;
		led_open_cath_pin = o;
		led_short_gnd_pin = s;
		tick(5);
		led_open_res_pin = 3'h0;
		led_open_cath_pin = 3'h0;
		led_short_gnd_pin = 3'h0;
		tick(5);
		status(8'hf8, 8'hc1, e5, e6, 0);
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic t_basic;
		chk("tx_valid", tx_valid, 8'h00);
		chk("armed", resp_armed, 8'h00);
		status(8'hf8, 8'hd0, 8'hf0, 8'h88, 0);
		status(8'hf8, 8'hc0, 8'hf0, 8'h88, 1);
		$display("test basic done");
	endtask
	task automatic t_temp;
		temp_warn_pin = 1'b1;
		temp_sd_pin = 1'b1;
		uv_pin = 1'b1;
		temp_info_pin = 2'h2;
		tick(5);
		temp_warn_pin = 1'b0;
		tick(5);
		status(8'hf8, 8'hee, 8'hf0, 8'h88, 0);
		status(8'hf8, 8'hea, 8'hf0, 8'h88, 0);
		temp_sd_pin = 1'b0;
		uv_pin = 1'b0;
		temp_info_pin = 2'h1;
		tick(5);
		status(8'hf8, 8'hc9, 8'hf0, 8'h88, 0);
		status(8'hf8, 8'hc1, 8'hf0, 8'h88, 0);
		$display("test thermal done");
	endtask
	task automatic t_led;
		led(3'h1, 3'h2, 3'h4, 8'hf3, 8'had);
		led(3'h4, 3'h1, 3'h2, 8'hf5, 8'hba);
		led(3'h2, 3'h4, 3'h1, 8'hf2, 8'hdb);
		status(8'hf8, 8'hc1, 8'hf0, 8'h88, 0);
		$display("test led done");
	endtask
	task automatic t_err;
		refuse(8'h81, {2'b11, addr ^ 6'h01}, 1'b0);
		refuse(8'h82, {2'b11, addr}, 1'b0);
		refuse(8'h01, {2'b11, addr}, 1'b0);
		refuse(8'h81, {2'b10, addr}, 1'b0);
		refuse(8'h81, {2'b11, addr}, 1'b1);
		hdr_err_evt = 1'b1;
		tick(1);
		hdr_err_evt = 1'b0;
		mon_bit = 1'b0;
		bit_sample = 1'b1;
		tick(1);
		bit_sample = 1'b0;
		tick(4);
		mon_bit = 1'b1;
		tick(2);
		status(8'hff, 8'hc1, 8'hf0, 8'h88, 0);
		data_err_evt = 1'b1;
		tick(1);
		data_err_evt = 1'b0;
		tick(2);
		status(8'hfc, 8'hc1, 8'hf0, 8'h88, 0);
		status(8'hf8, 8'hc1, 8'hf0, 8'h88, 0);
		$display("test errors done");
	endtask
	task automatic t_derate;
		thermal_derate_on = 1'b1;
		thermal_derate_level = 4'h0;
		retry_active = 1'b1;
		led_enable = 3'b011;
		leds_on = 1'b0;
		group_select = 4'h6;
		tick(2);
		status(8'hf8, 8'hc1, 8'h08, 8'h88, 2);
		retry_active = 1'b0;
		thermal_derate_level = 4'he;
		tick(2);
		status(8'hf8, 8'hc1, 8'he8, 8'h88, 2);
		status(8'hf8, 8'hc1, 8'he0, 8'h88, 0);
		$display("test derate done");
	endtask
	// abort, freeze and a reset in mid-run
	task automatic t_ctl;
		logic [7:0] b[8];
		logic [7:0] g[9];
		int n;
		b = '{8'h80, 8'h81, {2'b11, addr}, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
		m.req(b, 1'b0);
		frame_abort = 1'b1;
		tick(1);
		frame_abort = 1'b0;
		chk("armed", resp_armed, 8'h00);
		m.rsp(0, g, n);
		chk("rsp count", n[7:0], 8'h00);
		// frozen: neither the header nor the warning pulse may count
		m.req(b, 1'b0);
		clk_en = 1'b0;
		temp_warn_pin = 1'b1;
		m.hdr(LFS_ID_RSP);
		tick(3);
		temp_warn_pin = 1'b0;
		tick(1);
		clk_en = 1'b1;
		tick(3);
		chk("armed", resp_armed, 8'h01);
		m.rsp(0, g, n);
		chk("rsp count", n[7:0], 8'h09);
		chk("err byte", g[2], 8'hf8);
		chk("temp byte", g[3], 8'hc1);
		rst_b = 1'b0;
		tick(2);
		chk("tx_valid", tx_valid, 8'h00);
		chk("tx_data", tx_data, 8'h00);
		chk("armed", resp_armed, 8'h00);
		rst_b = 1'b1;
		status(8'hf8, 8'hd1, 8'he0, 8'h88, 0);
		$display("test control done");
	endtask
	// ------------------------------------------------
	// clock, watchdog, main sequence
	// ------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// the full run needs about 930 cycles
	initial begin
		#(4000 * 100);
		failures++;
		report_and_stop;
	end
	initial begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		frame_abort = 1'b0;
		hdr_err_evt = 1'b0;
		data_err_evt = 1'b0;
		tx_bit = 1'b1;
		bit_sample = 1'b0;
		mon_bit = 1'b1;
		temp_warn_pin = 1'b0;
		temp_sd_pin = 1'b0;
		uv_pin = 1'b0;
		temp_info_pin = 2'h0;
		led_open_res_pin = 3'h0;
		led_open_cath_pin = 3'h0;
		led_short_gnd_pin = 3'h0;
		retry_active = 1'b0;
		thermal_derate_on = 1'b0;
		thermal_derate_level = 4'h5;
		led_enable = 3'b110;
		leds_on = 1'b1;
		group_select = 4'h9;
		tick(10);
		rst_b = 1'b1;
		t_basic;
		t_temp;
		t_led;
		t_err;
		t_derate;
		t_ctl;
		report_and_stop;
	end
endmodule
